// File: rtl/dcb_pkg.sv
// constants for the disk control bus command interpreter
package dcb_pkg;
	// ************************************************************
	// command codes
	// ************************************************************
	localparam logic [7:0] CMD_REPORT_ILLEGAL = 8'h00;
	localparam logic [7:0] CMD_CLEAR_FAULT = 8'h01;
	localparam logic [7:0] CMD_CLEAR_ATTN = 8'h02;
	localparam logic [7:0] CMD_SEEK = 8'h03;
	localparam logic [7:0] CMD_REZERO = 8'h04;
	localparam logic [7:0] CMD_SENSE2 = 8'h0d;
	localparam logic [7:0] CMD_SENSE1 = 8'h0e;
	localparam logic [7:0] CMD_GEN_STATUS = 8'h0f;
	localparam logic [7:0] CMD_REPORT_ATTR = 8'h10;
	localparam logic [7:0] CMD_SET_ATTN = 8'h11;
	localparam logic [7:0] CMD_SEL_RESET = 8'h14;
	localparam logic [7:0] CMD_PARTITION = 8'h16;
	localparam logic [7:0] CMD_REPORT_CYL_HI = 8'h29;
	localparam logic [7:0] CMD_REPORT_CYL_LO = 8'h2a;
	localparam logic [7:0] CMD_REPORT_TEST = 8'h2f;
	localparam logic [7:0] CMD_ATTN_CTRL = 8'h40;
	localparam logic [7:0] CMD_WRITE_CTRL = 8'h41;
	localparam logic [7:0] CMD_CYL_HI = 8'h42;
	localparam logic [7:0] CMD_CYL_LO = 8'h43;
	localparam logic [7:0] CMD_HEAD = 8'h44;
	localparam logic [7:0] CMD_ATTR_NUM = 8'h50;
	localparam logic [7:0] CMD_ATTR_VAL = 8'h51;
	localparam logic [7:0] CMD_SPIN = 8'h55;
	localparam logic [7:0] CMD_SPT_HI = 8'h59;
	localparam logic [7:0] CMD_SPT_MID = 8'h5a;
	localparam logic [7:0] CMD_SPT_LO = 8'h5b;
	localparam logic [7:0] CMD_LOAD_TEST = 8'h6f;

	// ************************************************************
	// fields, reset values, sizes
	// ************************************************************
	localparam int CTRL_BIT = 7;
	localparam int GS_BUSY_EXEC = 0;
	localparam int GS_ATTN = 1;
	localparam int GS_ILLEGAL_CMD = 2;
	localparam int ATTR_DEPTH = 32;
	localparam int ATTR_AW = 5;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_SPIN = 1'b1;
	localparam logic RST_ATTN_EN = 1'b1;
	localparam logic RST_WRITE_EN = 1'b0;
	localparam logic [23:0] RST_SPT = 24'h000000;

	// ************************************************************
	// handshake states
	// ************************************************************
	typedef enum logic [2:0] {
		DCB_IDLE = 3'b000,
		DCB_CMD_ACK = 3'b001,
		DCB_WAIT_PARAM = 3'b010,
		DCB_EXEC = 3'b011,
		DCB_PARAM_ACK = 3'b100
	} dcb_state_e;
endpackage : dcb_pkg

// File: rtl/dcb_decode.sv
// command byte decoder: direction and command class
`timescale 1ns/1ps
module dcb_decode
	import dcb_pkg::*;
(
	input wire logic [7:0] cmd,
	output logic param_out,
	output logic time_dep,
	output logic known
);
	always_comb
	begin
		param_out = 1'b0;
		time_dep = 1'b0;
		known = 1'b1;
		unique case (cmd)
			CMD_ATTN_CTRL, CMD_WRITE_CTRL, CMD_CYL_HI, CMD_CYL_LO, CMD_HEAD,
			CMD_ATTR_NUM, CMD_ATTR_VAL, CMD_SPT_HI, CMD_SPT_MID, CMD_SPT_LO,
			CMD_LOAD_TEST:
				param_out = 1'b1;
			CMD_SPIN:
			begin
				param_out = 1'b1;
				time_dep = 1'b1;
			end
			CMD_SEEK, CMD_REZERO, CMD_SET_ATTN, CMD_SEL_RESET, CMD_PARTITION:
				time_dep = 1'b1;
			CMD_REPORT_ILLEGAL, CMD_CLEAR_FAULT, CMD_CLEAR_ATTN, CMD_SENSE2,
			CMD_SENSE1, CMD_GEN_STATUS, CMD_REPORT_ATTR, CMD_REPORT_CYL_HI,
			CMD_REPORT_CYL_LO, CMD_REPORT_TEST:
				known = 1'b1;
			default:
				known = 1'b0;
		endcase
	end
endmodule : dcb_decode

// File: rtl/dcb_cmd_if.sv
// device side command interpreter for the byte wide disk control bus
`timescale 1ns/1ps
module dcb_cmd_if
	import dcb_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CMD_REQ,
	input wire logic PARAM_REQ,
	input wire logic BUS_DIR_OUT,
	input wire logic [7:0] BUS_IN,
	output logic [7:0] BUS_OUT,
	output logic BUS_OE,
	output logic BUS_ACK,
	output logic BUSY,
	output logic ATTN,
	input wire logic OP_DONE,
	input wire logic OP_FAIL,
	input wire logic EVENT_ATTN,
	input wire logic [7:0] SENSE1,
	input wire logic [7:0] SENSE2,
	output logic OP_START,
	output logic [7:0] OP_CMD,
	output logic [15:0] OP_CYL,
	output logic [7:0] OP_HEAD,
	output logic [23:0] OP_SPT,
	output logic OP_SPIN_UP,
	output logic WRITE_EN
);
	// ************************************************************
	// reset release and input synchronisers
	// ************************************************************
	logic rst_s1, rst_n_q;
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_s1 <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n_q <= rst_s1;
		end
	end

	logic [11:0] sync1, sync2;
	always_ff @(posedge REF_CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= {CMD_REQ, PARAM_REQ, BUS_DIR_OUT, 1'b0, BUS_IN};
			sync2 <= sync1;
		end
	end
	logic cmd_req, param_req, dir_out;
	logic [7:0] bus_in;
	assign cmd_req = sync2[11];
	assign param_req = sync2[10];
	assign dir_out = sync2[9];
	assign bus_in = sync2[7:0];

	// ************************************************************
	// command decode
	// ************************************************************
	logic [7:0] cmd;
	logic dec_out, dec_td, dec_known;
	dcb_decode i_dcb_decode (
		.cmd(cmd),
		.param_out(dec_out),
		.time_dep(dec_td),
		.known(dec_known)
	);

	// ************************************************************
	// handshake state machine
	// ************************************************************
	dcb_state_e state;
	logic busy_exec, attn_cond, attn_en, illegal;
	logic [7:0] cyl_hi, cyl_lo, head, test_byte, attr_num;
	logic [23:0] spt;
	logic [7:0] attr [ATTR_DEPTH];
	logic spin_up;
	logic [7:0] status_byte, reply;

	// unused status bits stay zero
	assign status_byte = {5'h00, illegal, attn_cond, busy_exec};

	// which byte a parameter-in command returns
	always_comb
	begin
		unique case (cmd)
			CMD_SENSE2: reply = SENSE2;
			CMD_SENSE1: reply = SENSE1;
			CMD_REPORT_ATTR: reply = attr[attr_num[ATTR_AW-1:0]];
			CMD_REPORT_CYL_HI: reply = cyl_hi;
			CMD_REPORT_CYL_LO: reply = cyl_lo;
			CMD_REPORT_TEST: reply = test_byte;
			default: reply = status_byte;
		endcase
	end

	// param phase valid only when direction agrees with the command
	logic param_ok, param_take;
	assign param_ok = param_req && (dir_out == dec_out);
	assign param_take = (state == DCB_WAIT_PARAM) && param_ok;

	always_ff @(posedge REF_CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state <= DCB_IDLE;
			cmd <= RST_BYTE;
			BUS_ACK <= 1'b0;
			BUS_OE <= 1'b0;
			BUS_OUT <= RST_BYTE;
		end
		else
		begin
			unique case (state)
				DCB_IDLE:
					// no acknowledge while busy first byte is the command
					if (cmd_req && dir_out && !BUSY)
					begin
						cmd <= bus_in;
						BUS_ACK <= 1'b1;
						state <= DCB_CMD_ACK;
					end
				DCB_CMD_ACK:
					if (!cmd_req)
					begin
						BUS_ACK <= 1'b0;
						state <= DCB_WAIT_PARAM;
					end
				DCB_WAIT_PARAM:
					if (param_take)
					begin
						// drive reply for inbound parameter
						BUS_OE <= !dec_out;
						BUS_OUT <= dec_out ? RST_BYTE : reply;
						state <= DCB_EXEC;
					end
				DCB_EXEC:
				begin
					// action and attention settle one cycle before acknowledge
					BUS_ACK <= 1'b1;
					state <= DCB_PARAM_ACK;
				end
				DCB_PARAM_ACK:
					if (!param_req)
					begin
						BUS_ACK <= 1'b0;
						BUS_OE <= 1'b0;
						state <= DCB_IDLE;
					end
				default:
					state <= DCB_IDLE;
			endcase
		end
	end

	// ************************************************************
	// parameter registers
	// ************************************************************
	logic out_wr;
	assign out_wr = param_take && dec_out;

	always_ff @(posedge REF_CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			cyl_hi <= RST_BYTE;
			cyl_lo <= RST_BYTE;
			head <= RST_BYTE;
			test_byte <= RST_BYTE;
			attr_num <= RST_BYTE;
			spt <= RST_SPT;
			spin_up <= RST_SPIN;
			attn_en <= RST_ATTN_EN;
			WRITE_EN <= RST_WRITE_EN;
		end
		else if (out_wr)
		begin
			unique case (cmd)
				CMD_ATTN_CTRL: attn_en <= !bus_in[CTRL_BIT];
				CMD_WRITE_CTRL: WRITE_EN <= bus_in[CTRL_BIT];
				CMD_SPIN: spin_up <= bus_in[CTRL_BIT];
				CMD_CYL_HI: cyl_hi <= bus_in;
				CMD_CYL_LO: cyl_lo <= bus_in;
				CMD_HEAD: head <= bus_in;
				CMD_SPT_HI: spt[23:16] <= bus_in;
				CMD_SPT_MID: spt[15:8] <= bus_in;
				CMD_SPT_LO: spt[7:0] <= bus_in;
				CMD_ATTR_NUM: attr_num <= bus_in;
				CMD_LOAD_TEST: test_byte <= bus_in;
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < ATTR_DEPTH; gi++)
		begin : g_attr
			always_ff @(posedge REF_CLK or negedge rst_n_q)
			begin
				if (!rst_n_q)
					attr[gi] <= RST_BYTE;
				else if (out_wr && cmd == CMD_ATTR_VAL && attr_num == 8'(gi))
					attr[gi] <= bus_in;
			end
		end
	endgenerate

	// ************************************************************
	// execution, busy and attention
	// ************************************************************
	logic exec_start, clear_attn;
	assign exec_start = param_take && dec_td;
	assign clear_attn = param_take && (cmd == CMD_CLEAR_FAULT || cmd == CMD_CLEAR_ATTN);

	always_ff @(posedge REF_CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			busy_exec <= 1'b0;
			BUSY <= 1'b0;
			OP_START <= 1'b0;
			OP_CMD <= RST_BYTE;
			OP_CYL <= '0;
			OP_HEAD <= RST_BYTE;
			OP_SPT <= RST_SPT;
			OP_SPIN_UP <= RST_SPIN;
		end
		else
		begin
			OP_START <= exec_start;
			if (exec_start)
			begin
				// snapshot parameters so later loads cannot disturb the run
				busy_exec <= 1'b1;
				BUSY <= 1'b1; // raised before acknowledge
				OP_CMD <= cmd;
				OP_CYL <= {cyl_hi, cyl_lo};
				OP_HEAD <= head;
				OP_SPT <= spt;
				OP_SPIN_UP <= (cmd == CMD_SPIN) ? bus_in[CTRL_BIT] : spin_up;
			end
			else if (OP_DONE && BUSY)
				BUSY <= 1'b0;
			// busy executing lasts until attention is cleared
			if (clear_attn && !exec_start)
				busy_exec <= 1'b0;
		end
	end

	logic imm_fail, td_done;
	// unknown code or failed immediate action raises attention before ack
	assign imm_fail = param_take && !dec_td && (!dec_known || OP_FAIL);
	assign td_done = OP_DONE && BUSY && !exec_start;

	always_ff @(posedge REF_CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			attn_cond <= 1'b0;
			illegal <= 1'b0;
			ATTN <= 1'b0;
		end
		else
		begin
			// a new event in the clearing cycle wins
			if (td_done || imm_fail || EVENT_ATTN)
				attn_cond <= 1'b1;
			else if (clear_attn)
				attn_cond <= 1'b0;
			if (param_take && !dec_known)
				illegal <= 1'b1;
			else if (clear_attn)
				illegal <= 1'b0;
			ATTN <= attn_cond && attn_en;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_busy_before_ack: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		exec_start |=> (BUSY && !BUS_ACK) ##1 BUS_ACK)
		else $error("ack before busy");
	a_no_ack_busy: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		(state == DCB_IDLE && BUSY) |=> !BUS_ACK)
		else $error("ack while busy");
	a_ack_after_exec: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		param_take |=> !BUS_ACK ##1 BUS_ACK)
		else $error("second ack timing");
	a_fail_attn: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		imm_fail |=> attn_cond && !BUS_ACK)
		else $error("attention late");
	a_done_attn: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		td_done |=> attn_cond)
		else $error("no attention at finish");
	a_clear_attn: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		(clear_attn && !td_done && !imm_fail && !EVENT_ATTN) |=> !attn_cond && !busy_exec)
		else $error("clear failed");
	a_in_drive: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		(param_take && !dec_out) |=> BUS_OE && BUS_OUT == $past(reply))
		else $error("reply not driven");
	a_attn_gate: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
		!attn_en |=> !ATTN)
		else $error("attention not gated");
endmodule : dcb_cmd_if

// File: sim/dcb_host_model.sv
// host side model that runs two-byte command sequences on the control bus
`timescale 1ns/1ps
module dcb_host_model (
	input wire logic clk,
	input wire logic ack,
	input wire logic [7:0] rd,
	output logic cmd_req,
	output logic param_req,
	output logic dir_out,
	output logic [7:0] bus,
	output logic got,
	output logic [7:0] got_data,
	output logic tmo
);
	// ************************************************************
	// handshake
	// ************************************************************
	initial
	begin
		cmd_req = 1'b0;
		param_req = 1'b0;
		dir_out = 1'b1;
		bus = 8'h00;
		got = 1'b0;
		got_data = 8'h00;
		tmo = 1'b0;
	end

	// write clock is the reference clock looped back; it stays static here
	// because this model never raises write gate
	logic wr_gate = 1'b0;
	logic wr_clk;
	assign wr_clk = clk & wr_gate;

	// long bound: a command sent while the device is busy waits for busy to fall
	task automatic wait_ack(input logic lvl);
		int n;
		for (n = 0; n < 400; n++)
		begin
			@(posedge clk);
			got <= 1'b0;
			if (ack === lvl)
				break;
			// released bus: keep it moving so a stale byte never looks valid
			if (!dir_out)
				bus <= ~bus;
		end
		if (n == 400)
			tmo <= 1'b1;
	endtask : wait_ack

	task automatic xfer(input logic [7:0] c, input logic outb, input logic [7:0] p);
		@(posedge clk);
		cmd_req <= 1'b1;
		dir_out <= 1'b1;
		bus <= c;
		wait_ack(1'b1);
		cmd_req <= 1'b0;
		wait_ack(1'b0);
		dir_out <= outb;
		bus <= outb ? p : ~c;
		param_req <= 1'b1;
		wait_ack(1'b1);
		got <= !outb;
		got_data <= rd;
		param_req <= 1'b0;
		wait_ack(1'b0);
	endtask : xfer
endmodule : dcb_host_model

// File: sim/dcb_cmd_if_test.sv
// self-checking bench for the disk control bus command interpreter
`timescale 1ns/1ps
module dcb_cmd_if_test
	import dcb_pkg::*;
;
	// ************************************************************
	// harness
	// ************************************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic op_done = 1'b0;
	logic op_fail = 1'b0;
	logic ev_attn = 1'b0;
	logic [7:0] s1 = 8'h00;
	logic [7:0] s2 = 8'h00;
	logic cmd_req, param_req, dir_out, ack, oe, busy, attn, op_start, spin_up, wen, got, tmo;
	logic [7:0] bus_in, bus_out, op_cmd, op_head, rdata, a, b, h;
	logic [15:0] op_cyl;
	logic [23:0] op_spt, spt;
	logic [8:0] ent;
	logic [8:0] q[$];
	logic [7:0] td[6] = '{CMD_SEEK, CMD_REZERO, CMD_PARTITION, CMD_SET_ATTN, CMD_SEL_RESET, CMD_SPIN};
	int err_total = 0;
	int comparisons = 0;
	int starts = 0;

	always #5 clk = ~clk;

	dcb_cmd_if i_dcb_cmd_if (
		.REF_CLK(clk), .RST_N(rst_n), .CMD_REQ(cmd_req), .PARAM_REQ(param_req),
		.BUS_DIR_OUT(dir_out), .BUS_IN(bus_in), .BUS_OUT(bus_out), .BUS_OE(oe),
		.BUS_ACK(ack), .BUSY(busy), .ATTN(attn), .OP_DONE(op_done), .OP_FAIL(op_fail),
		.EVENT_ATTN(ev_attn), .SENSE1(s1), .SENSE2(s2), .OP_START(op_start),
		.OP_CMD(op_cmd), .OP_CYL(op_cyl), .OP_HEAD(op_head), .OP_SPT(op_spt),
		.OP_SPIN_UP(spin_up), .WRITE_EN(wen)
	);

	dcb_host_model i_dcb_host_model (
		.clk(clk), .ack(ack), .rd(bus_out), .cmd_req(cmd_req), .param_req(param_req),
		.dir_out(dir_out), .bus(bus_in), .got(got), .got_data(rdata), .tmo(tmo)
	);

	// ************************************************************
	// checking
	// ************************************************************
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			err_total++;
		end
	endtask : chk

	task automatic results;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// e[8] marks a reply whose value is worth comparing
	task automatic seq(input logic [7:0] c, input logic outb, input logic [7:0] p,
			input logic [8:0] e);
		if (!outb)
			q.push_back(e);
		i_dcb_host_model.xfer(c, outb, p);
	endtask : seq

	// d high pulses completion, low pulses a spontaneous event
	task automatic hit(input logic d);
		@(posedge clk);
		op_done <= d;
		ev_attn <= !d;
		@(posedge clk);
		op_done <= 1'b0;
		ev_attn <= 1'b0;
	endtask : hit

	always @(posedge clk)
		if (got === 1'b1)
		begin
			chk(oe, 1);
			if (q.size() == 0)
				chk(24'h1, 24'h0);
			else
			begin
				ent = q.pop_front();
				if (ent[8])
					chk(rdata, ent[7:0]);
			end
		end

	// launch pulses of time-dependent commands
	always @(posedge clk)
		if (op_start === 1'b1)
			starts++;

	always @(posedge tmo)
	begin
		err_total++;
		results();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		void'($urandom(88));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk({wen, spin_up, attn, busy}, 4'b0100);
		seq(CMD_GEN_STATUS, 0, 0, 9'h100);
		for (int i = 0; i < 4; i++)
		begin
			a = 8'($urandom);
			b = 8'($urandom);
			seq(CMD_LOAD_TEST, 1, a, 0);
			seq(CMD_REPORT_TEST, 0, 0, {1'b1, a});
			seq(CMD_CYL_HI, 1, a, 0);
			seq(CMD_CYL_LO, 1, b, 0);
			seq(CMD_REPORT_CYL_HI, 0, 0, {1'b1, a});
			seq(CMD_REPORT_CYL_LO, 0, 0, {1'b1, b});
			seq(CMD_ATTR_NUM, 1, b & 8'h1f, 0);
			seq(CMD_ATTR_VAL, 1, ~a, 0);
			seq(CMD_REPORT_ATTR, 0, 0, {1'b1, ~a});
		end
		h = 8'($urandom);
		spt = 24'($urandom);
		seq(CMD_HEAD, 1, h, 0);
		seq(CMD_SPT_HI, 1, spt[23:16], 0);
		seq(CMD_SPT_MID, 1, spt[15:8], 0);
		seq(CMD_SPT_LO, 1, spt[7:0], 0);
		foreach (td[i])
		begin
			seq(td[i], td[i] == CMD_SPIN, 8'h00, 0);
			chk({busy, op_cmd, op_head}, {1'b1, td[i], h});
			chk(op_spt, spt);
			fork
				seq(CMD_CYL_HI, 1, ~a, 0);
				begin
					repeat (20) @(posedge clk);
					// an early acknowledge would have let the host drop its request
					chk({ack, cmd_req}, 2'b01);
					hit(1'b1);
				end
			join
			repeat (4) @(posedge clk);
			chk({busy, attn, op_cyl}, {2'b01, a, b});
			seq(CMD_GEN_STATUS, 0, 0, 9'h103);
			seq(CMD_CLEAR_ATTN, 0, 0, 0);
			seq(CMD_GEN_STATUS, 0, 0, 9'h100);
			seq(CMD_CYL_HI, 1, a, 0);
		end
		chk(spin_up, 0);
		seq(CMD_ATTN_CTRL, 1, 8'h80, 0);
		hit(1'b0);
		repeat (4) @(posedge clk);
		chk(attn, 0);
		seq(CMD_GEN_STATUS, 0, 0, 9'h102);
		seq(CMD_ATTN_CTRL, 1, 8'h00, 0);
		repeat (4) @(posedge clk);
		chk(attn, 1);
		seq(CMD_CLEAR_FAULT, 0, 0, 0);
		op_fail <= 1'b1;
		seq(CMD_CYL_LO, 1, b, 0);
		op_fail <= 1'b0;
		chk(attn, 1);
		seq(CMD_GEN_STATUS, 0, 0, 9'h102);
		seq(CMD_CLEAR_FAULT, 0, 0, 0);
		seq(CMD_GEN_STATUS, 0, 0, 9'h100);
		seq(CMD_WRITE_CTRL, 1, 8'h80, 0);
		chk(wen, 1);
		seq(CMD_WRITE_CTRL, 1, 8'h00, 0);
		chk(wen, 0);
		// an undefined code raises attention and the illegal command bit
		seq(8'h7e, 0, 0, 9'h100);
		seq(CMD_REPORT_ILLEGAL, 0, 0, 9'h106);
		seq(CMD_CLEAR_FAULT, 0, 0, 9'h106);
		seq(CMD_GEN_STATUS, 0, 0, 9'h100);
		a = 8'($urandom);
		b = 8'($urandom);
		s1 <= a;
		s2 <= b;
		seq(CMD_SENSE1, 0, 0, {1'b1, a});
		seq(CMD_SENSE2, 0, 0, {1'b1, b});
		repeat (4) @(posedge clk);
		chk(q.size(), 0);
		chk(starts, 6);
		results();
	end
endmodule : dcb_cmd_if_test
